// >>> include/seg_mmu_pkg.sv
// Package: register map, mode fields, command codes and bus structs
package seg_mmu_pkg;
  // Internal register addresses and command codes (high byte of I/O address)
  localparam logic [7:0] REG_MODE_ADDR   = 8'h00;
  localparam logic [7:0] REG_DPTR_ADDR   = 8'h01;
  localparam logic [7:0] CMD_DESC_LOAD   = 8'h02;
  // Mode register field positions
  localparam int MODE_OUT_EN_BIT       = 7;
  localparam int MODE_XLAT_EN_BIT      = 6;
  localparam int MODE_UPPER_BIT        = 5;
  localparam int MODE_MULTI_TBL_BIT    = 4;
  localparam int MODE_NORMAL_MATCH_BIT = 3;
  localparam int MODE_ID_LSB   = 0;
  localparam int MODE_ID_W     = 3;
  // Reset values
  localparam logic [7:0] MODE_RST_SELECTED = 8'h80;
  localparam logic [7:0] MODE_RST_OTHER    = 8'h00;
  localparam logic [7:0] DPTR_RST          = 8'h00;
  // Descriptor geometry
  localparam int DESC_COUNT     = 64;
  localparam int DESC_BYTES     = 4;
  localparam int SEG_NUM_W      = 7;
  localparam int PHYS_ADDR_W    = 24;
  localparam int TRAP_LINE_BASE = 8;

  // Processor-side bus sample
  typedef struct packed {
    logic [6:0]  segment_number_lines;
    logic [15:0] address_data;
    logic        addr_strobe;
    logic        normal_mode_n;
    logic        sio_write;
    logic        trap_ack;
  } cpu_bus_t;

  // One segment descriptor
  typedef struct packed {
    logic [15:0] base;
    logic [7:0]  size;
    logic [7:0]  attr;
  } descriptor_t;
endpackage : seg_mmu_pkg

// >>> hdl/segment_mmu_control.sv
// Segment translation unit: mode/pointer registers, descriptors, address output
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Selected-at-reset unit comes up with master enable set, translate clear.
// - Master enable clear keeps all address outputs high impedance.
// - Translate set maps addresses; clear passes logical address as 23 bits.
// - Upper range bit picks segments 64-127, else 0-63.
// - Multi-table bit requires normal/system input to match match bit.
// - Chip select gates command recognition only, never translation.
// - Trap acknowledge drives line 8 plus identifier high, the other seven high lines floating.
// - I/O high byte is opcode/register, low byte is the data byte written.
// - Register address 1 is descriptor pointer, 0 is mode register.
// - Command 2 loads a descriptor then increments the pointer.
// - Descriptor pointer picks one of 64 descriptor registers.
// - Four bytes are taken before the pointer advances.
// - Descriptor: 16-bit base times 256, size byte, attribute byte.
// - Mode byte with top two bits set enables and translates, id zero.
// - Reset-selected unit passes processor's first accesses untranslated.
// - Units not selected at reset float their address outputs.
// - Pass-through maps segment N offset K to K plus N times 65536.
module segment_mmu_control #(
  parameter int NUM_DESC = seg_mmu_pkg::DESC_COUNT
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Processor bus pins
  input  wire logic [6:0]  segment_number_lines,
  input  wire logic [15:0] address_data_in,
  input  wire logic        addr_strobe,
  input  wire logic        normal_mode_n,
  input  wire logic        sio_write,
  input  wire logic        trap_ack,
  input  wire logic        chip_select_n,
  // Translated address out
  output logic [23:0]      phys_addr,
  output logic [23:0]      phys_addr_oe_n,
  // Trap identification drive onto address/data high lines
  output logic [7:0]       address_data_high_lines_out,
  output logic [7:0]       address_data_high_lines_oe_n,
  // State visible to the system
  output logic [7:0]       translation_mode,
  output logic [7:0]       descriptor_pointer
);

  // Two-stage input synchronisers
  seg_mmu_pkg::cpu_bus_t bus_s1_r;
  seg_mmu_pkg::cpu_bus_t bus_s2_r;
  logic                  cs_s1_r;
  logic                  cs_s2_r;
  logic                  sio_prev_r;
  logic                  as_prev_r;

  // Register state
  logic [7:0]                mode_r;
  logic [7:0]                dptr_r;
  logic [1:0]                byte_cnt_r;
  logic [23:0]               desc_shift_r;
  seg_mmu_pkg::descriptor_t  desc_mem [NUM_DESC];
  logic                      reset_sel_r;

  // Decoded events
  logic       sio_event;
  logic       cmd_taken;
  logic [7:0] cmd_code;
  logic [7:0] wr_byte;
  logic       as_event;

  // Mode fields
  logic       master_output_enable;
  logic       translate_enable;
  logic       upper_range_select;
  logic       multi_table_enable;
  logic       normal_mode_match;
  logic [2:0] mode_id;

  // Index from pointer
  function automatic logic [5:0] desc_index(input logic [7:0] ptr);
    desc_index = ptr[5:0];
  endfunction : desc_index

  // Synchronise all pins
  always_ff @(posedge clk_sys)
  begin
    bus_s1_r <= '{segment_number_lines, address_data_in, addr_strobe,
                  normal_mode_n, sio_write, trap_ack};
    bus_s2_r <= bus_s1_r;
    cs_s1_r  <= chip_select_n;
    cs_s2_r  <= cs_s1_r;
  end

  // Edge history for strobes
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      sio_prev_r <= 1'b0;
      as_prev_r  <= 1'b0;
    end
    else
    begin
      sio_prev_r <= bus_s2_r.sio_write;
      as_prev_r  <= bus_s2_r.addr_strobe;
    end
  end

  // Command decode
  assign sio_event = bus_s2_r.sio_write && !sio_prev_r;
  assign cmd_taken = sio_event && !cs_s2_r;
  assign cmd_code  = bus_s2_r.address_data[15:8];
  assign wr_byte   = bus_s2_r.address_data[7:0];
  assign as_event  = bus_s2_r.addr_strobe && !as_prev_r;

  // Mode field decode
  assign master_output_enable = mode_r[seg_mmu_pkg::MODE_OUT_EN_BIT];
  assign translate_enable     = mode_r[seg_mmu_pkg::MODE_XLAT_EN_BIT];
  assign upper_range_select   = mode_r[seg_mmu_pkg::MODE_UPPER_BIT];
  assign multi_table_enable   = mode_r[seg_mmu_pkg::MODE_MULTI_TBL_BIT];
  assign normal_mode_match    = mode_r[seg_mmu_pkg::MODE_NORMAL_MATCH_BIT];
  assign mode_id = mode_r[seg_mmu_pkg::MODE_ID_LSB +: seg_mmu_pkg::MODE_ID_W];

  // Chip select level seen during reset marks the boot unit
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      reset_sel_r <= cs_s2_r;
  end

  // Mode register
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      mode_r <= cs_s2_r ? seg_mmu_pkg::MODE_RST_SELECTED
                        : seg_mmu_pkg::MODE_RST_OTHER;
    else if (cmd_taken && cmd_code == seg_mmu_pkg::REG_MODE_ADDR)
      mode_r <= wr_byte;
  end

  // Descriptor pointer and byte counter
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      dptr_r     <= seg_mmu_pkg::DPTR_RST;
      byte_cnt_r <= 2'd0;
    end
    else if (cmd_taken && cmd_code == seg_mmu_pkg::REG_DPTR_ADDR)
    begin
      dptr_r     <= wr_byte;
      byte_cnt_r <= 2'd0;
    end
    else if (cmd_taken && cmd_code == seg_mmu_pkg::CMD_DESC_LOAD)
    begin
      byte_cnt_r <= byte_cnt_r + 2'd1;
      if (byte_cnt_r == 2'(seg_mmu_pkg::DESC_BYTES - 1))
        dptr_r <= dptr_r + 8'd1;
    end
  end

  // Descriptor byte assembly: base high, base low, size, attribute
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      desc_shift_r <= 24'h00_0000;
    else if (cmd_taken && cmd_code == seg_mmu_pkg::CMD_DESC_LOAD)
      desc_shift_r <= {desc_shift_r[15:0], wr_byte};
  end

  // Descriptor store on fourth byte
  always_ff @(posedge clk_sys)
  begin
    if (cmd_taken && cmd_code == seg_mmu_pkg::CMD_DESC_LOAD
        && byte_cnt_r == 2'(seg_mmu_pkg::DESC_BYTES - 1))
      desc_mem[desc_index(dptr_r)] <= {desc_shift_r, wr_byte};
  end

  // Translation path
  logic                     seg_hit;
  logic                     table_ok;
  seg_mmu_pkg::descriptor_t cur_desc;
  logic [23:0]              xlat_addr;
  logic [23:0]              pass_addr;

  assign seg_hit   = (bus_s2_r.segment_number_lines[6] == upper_range_select);
  assign table_ok  = !multi_table_enable
                   || (bus_s2_r.normal_mode_n == normal_mode_match);
  assign cur_desc  = desc_mem[bus_s2_r.segment_number_lines[5:0]];
  assign xlat_addr = {cur_desc.base, 8'h00}
                   + {8'h00, bus_s2_r.address_data};
  assign pass_addr = {1'b0, bus_s2_r.segment_number_lines,
                      bus_s2_r.address_data};

  // Address output register
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      phys_addr      <= 24'h00_0000;
      phys_addr_oe_n <= 24'hFF_FFFF;
    end
    else if (!master_output_enable)
    begin
      phys_addr      <= 24'h00_0000;
      phys_addr_oe_n <= 24'hFF_FFFF;
    end
    else if (as_event)
    begin
      phys_addr_oe_n <= 24'h00_0000;
      if (translate_enable && seg_hit && table_ok)
        phys_addr <= xlat_addr;
      else if (!translate_enable)
        phys_addr <= pass_addr;
    end
  end

  // Trap acknowledge identification drive
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      address_data_high_lines_out  <= 8'h00;
      address_data_high_lines_oe_n <= 8'hFF;
    end
    else if (bus_s2_r.trap_ack && master_output_enable)
    begin
      address_data_high_lines_out  <= 8'(1) << mode_id;
      address_data_high_lines_oe_n <= ~(8'(1) << mode_id);
    end
    else
    begin
      address_data_high_lines_out  <= 8'h00;
      address_data_high_lines_oe_n <= 8'hFF;
    end
  end

  // Status copies
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      translation_mode   <= seg_mmu_pkg::MODE_RST_OTHER;
      descriptor_pointer <= seg_mmu_pkg::DPTR_RST;
    end
    else
    begin
      translation_mode   <= mode_r;
      descriptor_pointer <= dptr_r;
    end
  end

  // Checks
  property p_out_float;
    @(posedge clk_sys) disable iff (!reset_n)
      !master_output_enable |=> (phys_addr_oe_n == 24'hFF_FFFF);
  endproperty
  a_out_float: assert property (p_out_float) else $error("outputs driven while disabled");

  property p_ptr_inc;
    @(posedge clk_sys) disable iff (!reset_n)
      (cmd_taken && cmd_code == seg_mmu_pkg::CMD_DESC_LOAD && byte_cnt_r == 2'd3)
      |=> (dptr_r == $past(dptr_r) + 8'd1);
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not advanced");

  property p_cs_gate;
    @(posedge clk_sys) disable iff (!reset_n)
      (sio_event && cs_s2_r) |=> $stable(mode_r) && $stable(dptr_r);
  endproperty
  a_cs_gate: assert property (p_cs_gate) else $error("command taken without select");

  property p_mode_wr;
    @(posedge clk_sys) disable iff (!reset_n)
      (cmd_taken && cmd_code == seg_mmu_pkg::REG_MODE_ADDR)
      |=> ##1 (translation_mode == $past(wr_byte, 2));
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode write lost");

  property p_pass;
    @(posedge clk_sys) disable iff (!reset_n)
      (master_output_enable && !translate_enable && as_event)
      |=> (phys_addr == {1'b0, $past(bus_s2_r.segment_number_lines),
                         $past(bus_s2_r.address_data)});
  endproperty
  a_pass: assert property (p_pass) else $error("pass-through address wrong");

  property p_trap;
    @(posedge clk_sys) disable iff (!reset_n)
      (bus_s2_r.trap_ack && master_output_enable)
      |=> (address_data_high_lines_oe_n[mode_id] == 1'b0)
        && ($countones(~address_data_high_lines_oe_n) == 1);
  endproperty
  a_trap: assert property (p_trap) else $error("trap id drive wrong");

  property p_cnt_hold;
    @(posedge clk_sys) disable iff (!reset_n)
      (cmd_taken && cmd_code == seg_mmu_pkg::CMD_DESC_LOAD && byte_cnt_r != 2'd3)
      |=> $stable(dptr_r);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("pointer moved early");

  property p_range;
    @(posedge clk_sys) disable iff (!reset_n)
      (master_output_enable && translate_enable && as_event && !seg_hit) |=> $stable(phys_addr);
  endproperty
  a_range: assert property (p_range) else $error("foreign segment translated");

  property p_boot_mode;
    @(posedge clk_sys) disable iff (!reset_n)
      $rose(reset_n) |-> (master_output_enable == reset_sel_r) && !translate_enable;
  endproperty
  a_boot_mode: assert property (p_boot_mode) else $error("reset mode wrong");

  property p_dptr_wr;
    @(posedge clk_sys) disable iff (!reset_n)
      (cmd_taken && cmd_code == seg_mmu_pkg::REG_DPTR_ADDR)
      |=> (dptr_r == $past(wr_byte));
  endproperty
  a_dptr_wr: assert property (p_dptr_wr) else $error("pointer write lost");

  property p_table;
    @(posedge clk_sys) disable iff (!reset_n)
      (master_output_enable && translate_enable && multi_table_enable && as_event
       && (bus_s2_r.normal_mode_n != normal_mode_match)) |=> $stable(phys_addr);
  endproperty
  a_table: assert property (p_table) else $error("wrong table translated");

  property p_low_byte;
    @(posedge clk_sys) disable iff (!reset_n)
      (master_output_enable && translate_enable && seg_hit && table_ok && as_event)
      |=> (phys_addr[7:0] == $past(bus_s2_r.address_data[7:0]));
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("offset low byte altered");

  property p_trap_drive;
    @(posedge clk_sys) disable iff (!reset_n)
      (bus_s2_r.trap_ack && master_output_enable)
      |=> (address_data_high_lines_out == ~address_data_high_lines_oe_n);
  endproperty
  a_trap_drive: assert property (p_trap_drive) else $error("trap line not high");

  property p_oe_on;
    @(posedge clk_sys) disable iff (!reset_n)
      (master_output_enable && as_event) |=> (phys_addr_oe_n == 24'h00_0000);
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("address not driven");

endmodule : segment_mmu_control
`default_nettype wire

// >>> tb/seg_cpu_model.sv
// Processor model: special I/O bytes, memory strobes, trap acknowledge
`timescale 1ns/1ps
`default_nettype none
module seg_cpu_model (
  // Clock, reset and boot wiring
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        boot_unit,
  // Pins toward the unit
  output var logic  [6:0]  segment_number_lines,
  output var logic  [15:0] address_data_in,
  output var logic         addr_strobe,
  output var logic         normal_mode_n,
  output var logic         sio_write,
  output var logic         trap_ack,
  output logic             chip_select_n
);
  logic sel_n_r;
  // Select tied high by reset on the boot unit only
  assign chip_select_n = reset_n ? sel_n_r : boot_unit;
  // Idle pins
  initial
  begin
    {segment_number_lines, address_data_in, addr_strobe, sio_write, trap_ack} = '0;
    normal_mode_n = 1'b1;
    sel_n_r       = 1'b1;
  end
  // One byte: code in high byte, selection decoded to select
  task automatic sio(input logic [7:0] code, input logic [7:0] data, input logic [7:0] sel);
    @(negedge clk_sys);
    address_data_in = {code, data};
    sel_n_r         = sel[1];
    sio_write       = 1'b1;
    repeat (2) @(negedge clk_sys);
    sio_write = 1'b0;
    repeat (6) @(negedge clk_sys);
    sel_n_r         = 1'b1;
    address_data_in = ~address_data_in;
  endtask : sio
  // Memory access, also used for the reset status fetches
  task automatic mem(input logic [6:0] seg, input logic [15:0] off, input logic nm);
    @(negedge clk_sys);
    segment_number_lines = seg;
    address_data_in      = off;
    normal_mode_n        = nm;
    addr_strobe          = 1'b1;
    repeat (2) @(negedge clk_sys);
    addr_strobe = 1'b0;
    repeat (4) @(negedge clk_sys);
    address_data_in = ~off;
  endtask : mem
  // Trap acknowledge status level
  task automatic trap(input logic v);
    @(negedge clk_sys);
    trap_ack = v;
    repeat (5) @(negedge clk_sys);
  endtask : trap
endmodule : seg_cpu_model
`default_nettype wire

// >>> tb/segment_mmu_control_test.sv
// Testbench for the segment translation unit
`timescale 1ns/1ps
`default_nettype none
module segment_mmu_control_test;
  logic        clk_sys, reset_n, boot_unit, sio_write, trap_ack, addr_strobe, normal_mode_n;
  logic        chip_select_n;
  logic [6:0]  seg_lines, seg;
  logic [15:0] ad_in, off;
  logic [23:0] phys_addr, phys_oe_n, hold;
  logic [7:0]  hi_out, hi_oe_n, mode, dptr;
  logic [15:0] base [3];
  int          fails, n_compared, cycles;
  seg_cpu_model u_cpu (.clk_sys(clk_sys), .reset_n(reset_n), .boot_unit(boot_unit),
    .segment_number_lines(seg_lines), .address_data_in(ad_in), .addr_strobe(addr_strobe),
    .normal_mode_n(normal_mode_n), .sio_write(sio_write), .trap_ack(trap_ack),
    .chip_select_n(chip_select_n));
  segment_mmu_control u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .segment_number_lines(seg_lines), .address_data_in(ad_in), .addr_strobe(addr_strobe),
    .normal_mode_n(normal_mode_n), .sio_write(sio_write), .trap_ack(trap_ack),
    .chip_select_n(chip_select_n), .phys_addr(phys_addr), .phys_addr_oe_n(phys_oe_n),
    .address_data_high_lines_out(hi_out), .address_data_high_lines_oe_n(hi_oe_n),
    .translation_mode(mode), .descriptor_pointer(dptr));
  // Clock and hang limit
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      test_done();
    end
  end
  function automatic logic [23:0] xlat(input logic [15:0] b, input logic [15:0] o);
    return {b, 8'h00} + {8'h00, o};
  endfunction : xlat
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t reg got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_addr(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t addr got %h exp %h", $time, got, exp);
    end
  endtask : chk_addr
  task automatic do_reset(input logic b);
    @(negedge clk_sys);
    reset_n   = 1'b0;
    boot_unit = b;
    repeat (8) @(negedge clk_sys);
    reset_n = 1'b1;
    // Status copies trail the registers by one edge
    repeat (2) @(negedge clk_sys);
  endtask : do_reset
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // Main sequence
  initial
  begin
    reset_n = 1'b0;
    boot_unit = 1'b1;
    void'($urandom(604));
    do_reset(1'b1);
    chk_reg(mode, 8'h80);
    for (int i = 0; i < 9; i++)
    begin
      seg = (i < 3) ? 7'h00 : 7'($urandom);
      off = (i < 3) ? 16'(2 * i + 2) : 16'($urandom);
      u_cpu.mem(seg, off, 1'b1);
      chk_addr(phys_addr, {1'b0, seg, off});
      chk_addr(phys_oe_n, 24'h00_0000);
    end
    $display("pass-through done");
    u_cpu.sio(8'h02, 8'h5A, 8'hFC);
    u_cpu.sio(8'h01, 8'h00, 8'hFC);
    chk_reg(dptr, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      base[i] = 16'($urandom);
      u_cpu.sio(8'h02, base[i][15:8], 8'hFC);
      u_cpu.sio(8'h02, base[i][7:0], 8'hFC);
      u_cpu.sio(8'h02, 8'($urandom), 8'hFC);
      u_cpu.sio(8'h02, 8'($urandom), 8'hFC);
      chk_reg(dptr, 8'(i + 1));
    end
    u_cpu.sio(8'h00, 8'hC0, 8'hFF);
    chk_reg(mode, 8'h80);
    u_cpu.sio(8'h00, 8'hC0, 8'hFC);
    chk_reg(mode, 8'hC0);
    for (int i = 0; i < 3; i++)
    begin
      off = 16'($urandom);
      u_cpu.mem(7'(i), off, 1'b1);
      chk_addr(phys_addr, xlat(base[i], off));
    end
    $display("descriptors done");
    u_cpu.sio(8'h00, 8'hE0, 8'hFC);
    u_cpu.mem(7'd65, 16'h1234, 1'b1);
    chk_addr(phys_addr, xlat(base[1], 16'h1234));
    hold = phys_addr;
    u_cpu.mem(7'd1, 16'h4321, 1'b1);
    chk_addr(phys_addr, hold);
    u_cpu.sio(8'h00, 8'hD8, 8'hFC);
    u_cpu.mem(7'd2, 16'h00FF, 1'b1);
    chk_addr(phys_addr, xlat(base[2], 16'h00FF));
    hold = phys_addr;
    u_cpu.mem(7'd0, 16'h0F0F, 1'b0);
    chk_addr(phys_addr, hold);
    u_cpu.sio(8'h00, 8'hC5, 8'hFC);
    u_cpu.trap(1'b1);
    chk_reg(hi_oe_n, 8'hDF);
    chk_reg(hi_out & 8'h20, 8'h20);
    u_cpu.trap(1'b0);
    u_cpu.sio(8'h00, 8'h00, 8'hFC);
    u_cpu.mem(7'd0, 16'h0008, 1'b1);
    chk_addr(phys_oe_n, 24'hFF_FFFF);
    do_reset(1'b0);
    chk_reg(mode, 8'h00);
    u_cpu.mem(7'd0, 16'h0002, 1'b1);
    chk_addr(phys_oe_n, 24'hFF_FFFF);
    $display("modes done");
    test_done();
  end
endmodule : segment_mmu_control_test
`default_nettype wire
